// *** verilog/cas_alarm_readback.sv ***
module cas_alarm_readback #(
  parameter int CNT_W = 16,
  parameter int INPUTS = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control port read
  input wire logic rdReq,
  input wire logic [cas_pkg::ADDR_W-1:0] rdAddr,
  output logic [cas_pkg::DATA_W-1:0] rdData_r,
  output logic rdValid_r,
  // control port requests
  input wire logic latchClearReq,
  input wire logic syncRequest,
  // mask registers held elsewhere
  input wire logic [7:0] referenceLoopMask,
  input wire logic [7:0] alarmMask,
  // reference loop status
  input wire logic [CNT_W-1:0] refLockCount,
  input wire logic [CNT_W-1:0] refLockLimit,
  input wire logic refAcquiring,
  input wire logic refLocked,
  input wire logic refHoldover,
  input wire logic [INPUTS-1:0] lossOfSignal,
  input wire logic [1:0] preferredInput,
  input wire logic [1:0] activeInputIndex,
  input wire logic [2:0] referenceLoopState,
  input wire logic [6:0] dacAverage,
  input wire logic [6:0] dacCurrent,
  input wire logic holdoverComparator,
  input wire logic activeInputLoss,
  input wire logic referenceFaster,
  input wire logic holdoverAdcMoving,
  input wire logic tuneOutOfRange,
  input wire logic [1:0] holdoverExitStep,
  // output loop and sync status
  input wire logic [CNT_W-1:0] outLockCount,
  input wire logic [CNT_W-1:0] outLockLimit,
  input wire logic outLoopLocked,
  input wire logic outLoopDisabled,
  input wire logic outLoopAcquiring,
  input wire logic phaseStable,
  input wire logic syncPulse,
  // summary alarm level
  output logic alarm_r
);
  logic refNearLock;
  logic outNearLock;
  logic neverSynced_r;
  logic [7:0] refAlarm;
  logic [7:0] combAlarm;
  logic [6:0] latchEvents;
  logic [6:0] latched;
  logic alarmNxt;
  logic [7:0] rdNxt;

  // reference loop near lock detector
  cas_near_lock #(.CNT_W(CNT_W)) u_refNear (
    .clk(clk),
    .reset(reset),
    .lockCount(refLockCount),
    .lockLimit(refLockLimit),
    .nearLock_r(refNearLock)
  );

  // output loop near lock detector
  cas_near_lock #(.CNT_W(CNT_W)) u_outNear (
    .clk(clk),
    .reset(reset),
    .lockCount(outLockCount),
    .lockLimit(outLockLimit),
    .nearLock_r(outNearLock)
  );

  // sync history: cleared by first sync, stays clear
  always_ff @(posedge clk) begin
    if (reset) begin
      neverSynced_r <= cas_pkg::NEVER_SYNCED_RESET;
    end else if (syncPulse || syncRequest) begin
      neverSynced_r <= 1'b0;
    end
  end

  // live reference loop alarm byte
  always_comb begin
    refAlarm = cas_pkg::BYTE_ZERO;
    refAlarm[cas_pkg::REF_NEAR_LOCK_BIT] = refNearLock;
    refAlarm[cas_pkg::REF_ACQUIRE_BIT] = refAcquiring;
    refAlarm[cas_pkg::REF_LOCKED_BIT] = refLocked;
    refAlarm[cas_pkg::REF_HOLDOVER_BIT] = refHoldover;
    refAlarm[cas_pkg::LOSS_LSB +: INPUTS] = lossOfSignal;
  end

  // live combined alarm byte
  always_comb begin
    combAlarm = cas_pkg::BYTE_ZERO;
    combAlarm[cas_pkg::SYNC_PENDING_BIT] =
      (outLoopLocked || outLoopDisabled) && neverSynced_r;
    combAlarm[cas_pkg::BOTH_LOCKED_BIT] = refLocked && outLoopLocked;
    combAlarm[cas_pkg::PHASE_STABLE_BIT] = phaseStable;
    combAlarm[cas_pkg::NEVER_SYNCED_BIT] = neverSynced_r;
    combAlarm[cas_pkg::OUT_LOCK_BIT] = outNearLock;
  end

  // masked summary of the live reference loop and combined alarm bytes
  assign alarmNxt = |(refAlarm & referenceLoopMask) | |(combAlarm & alarmMask);

  always_ff @(posedge clk) begin
    if (reset) begin
      alarm_r <= 1'b0;
    end else begin
      alarm_r <= alarmNxt;
    end
  end

  // event sources for the latched record
  always_comb begin
    latchEvents = 7'h00;
    latchEvents[cas_pkg::LAT_OUT_ACQUIRE_BIT] = outLoopAcquiring;
    latchEvents[cas_pkg::LAT_REF_ACQUIRE_BIT] = refAcquiring;
    latchEvents[cas_pkg::LAT_HOLDOVER_BIT] = refHoldover;
    latchEvents[cas_pkg::LOSS_LSB +: INPUTS] = lossOfSignal;
  end

  cas_sticky_bits #(.N(7)) u_latch (
    .clk(clk),
    .reset(reset),
    .eventIn(latchEvents),
    .clearReq(latchClearReq),
    .held_r(latched)
  );

  // read multiplexer
  always_comb begin
    rdNxt = cas_pkg::BYTE_ZERO;
    case (rdAddr)
      cas_pkg::ALARM_SUMMARY_READBACK: begin
        rdNxt[0] = alarm_r;
      end
      cas_pkg::REFERENCE_LOOP_ALARM_LIVE: begin
        rdNxt = refAlarm;
      end
      cas_pkg::COMBINED_ALARM_LIVE: begin
        rdNxt = combAlarm;
      end
      cas_pkg::ALARM_LATCHED_RECORD: begin
        rdNxt = {1'b0, latched};
      end
      cas_pkg::REFERENCE_LOOP_SELECT_STATE: begin
        rdNxt[cas_pkg::PREFERRED_LSB +: 2] = preferredInput;
        rdNxt[cas_pkg::ACTIVE_LSB +: 2] = activeInputIndex;
        rdNxt[cas_pkg::STATE_LSB +: 3] = referenceLoopState;
      end
      cas_pkg::HOLDOVER_DAC_AVERAGE: begin
        rdNxt = {1'b0, dacAverage};
      end
      cas_pkg::HOLDOVER_DAC_CURRENT: begin
        rdNxt = {holdoverComparator, dacCurrent};
      end
      cas_pkg::REFERENCE_LOOP_INPUT_FLAGS: begin
        rdNxt = {4'h0, activeInputLoss, referenceFaster,
                 holdoverAdcMoving, tuneOutOfRange};
      end
      cas_pkg::HOLDOVER_EXIT_PROGRESS: begin
        rdNxt[cas_pkg::EXIT_STEP_LSB +: 2] = holdoverExitStep;
      end
      default: begin
        rdNxt = cas_pkg::BYTE_ZERO; // spare and unmapped read zero
      end
    endcase
  end

  // registered read answer, one cycle after the request
  always_ff @(posedge clk) begin
    if (reset) begin
      rdData_r <= cas_pkg::BYTE_ZERO;
      rdValid_r <= 1'b0;
    end else begin
      rdValid_r <= rdReq;
      if (rdReq) begin
        rdData_r <= rdNxt;
      end
    end
  end
endmodule

// *** verilog/cas_pkg.sv ***
package cas_pkg;
  // control port address and data widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [15:0] ALARM_SUMMARY_READBACK = 16'h007b;
  localparam logic [15:0] REFERENCE_LOOP_ALARM_LIVE = 16'h007c;
  localparam logic [15:0] COMBINED_ALARM_LIVE = 16'h007d;
  localparam logic [15:0] ALARM_LATCHED_RECORD = 16'h007e;
  localparam logic [15:0] ALARM_READBACK_SPARE = 16'h007f;
  localparam logic [15:0] REFERENCE_LOOP_SELECT_STATE = 16'h0082;
  localparam logic [15:0] HOLDOVER_DAC_AVERAGE = 16'h0083;
  localparam logic [15:0] HOLDOVER_DAC_CURRENT = 16'h0084;
  localparam logic [15:0] REFERENCE_LOOP_INPUT_FLAGS = 16'h0085;
  localparam logic [15:0] HOLDOVER_EXIT_PROGRESS = 16'h0086;
  localparam logic [15:0] REFERENCE_LOOP_STATUS_SPARE = 16'h0087;

  // reference loop alarm field positions
  localparam int REF_NEAR_LOCK_BIT = 7;
  localparam int REF_ACQUIRE_BIT = 6;
  localparam int REF_LOCKED_BIT = 5;
  localparam int REF_HOLDOVER_BIT = 4;
  localparam int LOSS_LSB = 0;

  // combined alarm field positions
  localparam int SYNC_PENDING_BIT = 4;
  localparam int BOTH_LOCKED_BIT = 3;
  localparam int PHASE_STABLE_BIT = 2;
  localparam int NEVER_SYNCED_BIT = 1;
  localparam int OUT_LOCK_BIT = 0;

  // latched record field positions
  localparam int LAT_OUT_ACQUIRE_BIT = 6;
  localparam int LAT_REF_ACQUIRE_BIT = 5;
  localparam int LAT_HOLDOVER_BIT = 4;

  // select/state and exit progress register field positions
  localparam int PREFERRED_LSB = 5;
  localparam int ACTIVE_LSB = 3;
  localparam int STATE_LSB = 0;
  localparam int EXIT_STEP_LSB = 3;

  // near-lock threshold: limit divided by sixteen
  localparam int NEAR_LOCK_SHIFT = 4;

  // reference loop state codes
  localparam logic [2:0] REF_STATE_RESET = 3'h0;
  localparam logic [2:0] REF_STATE_ACQUIRE = 3'h1;
  localparam logic [2:0] REF_STATE_LOCKED = 3'h2;
  localparam logic [2:0] REF_STATE_INVALID = 3'h3;
  localparam logic [2:0] REF_STATE_HOLDOVER = 3'h4;
  localparam logic [2:0] REF_STATE_DAC_EXIT = 3'h5;

  // reset values
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic NEVER_SYNCED_RESET = 1'b1;
endpackage

// *** verilog/cas_near_lock.sv ***
module cas_near_lock #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // lock detection counter and its programmed limit
  input wire logic [CNT_W-1:0] lockCount,
  input wire logic [CNT_W-1:0] lockLimit,
  // near-lock level
  output logic nearLock_r
);
  logic [CNT_W-1:0] threshold;

  // one sixteenth of the limit
  assign threshold = lockLimit >> cas_pkg::NEAR_LOCK_SHIFT;

  // declare near lock once the counter reaches the threshold
  always_ff @(posedge clk) begin
    if (reset) begin
      nearLock_r <= 1'b0;
    end else begin
      nearLock_r <= (lockCount >= threshold);
    end
  end
endmodule

// *** verilog/cas_sticky_bits.sv ***
module cas_sticky_bits #(
  parameter int N = 7
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // event levels and clear pulse
  input wire logic [N-1:0] eventIn,
  input wire logic clearReq,
  // held record
  output logic [N-1:0] held_r
);
  // one sticky flag per event, set wins over clear
  for (genvar i = 0; i < N; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (reset) begin
        held_r[i] <= 1'b0;
      end else if (eventIn[i]) begin
        held_r[i] <= 1'b1;
      end else if (clearReq) begin
        held_r[i] <= 1'b0;
      end
    end
  end
endmodule

// *** sim/cas_alarm_readback_sva.sv ***
module cas_alarm_readback_sva #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control port read
  input wire logic rdReq,
  input wire logic [cas_pkg::ADDR_W-1:0] rdAddr,
  input wire logic [cas_pkg::DATA_W-1:0] rdData_r,
  input wire logic alarm_r,
  // masks and status
  input wire logic [7:0] referenceLoopMask,
  input wire logic [7:0] alarmMask,
  input wire logic [CNT_W-1:0] refLockCount,
  input wire logic [CNT_W-1:0] refLockLimit,
  input wire logic refLocked,
  input wire logic outLoopLocked,
  input wire logic phaseStable,
  input wire logic syncPulse,
  input wire logic syncRequest,
  input wire logic [1:0] preferredInput,
  input wire logic [1:0] activeInputIndex,
  input wire logic [2:0] referenceLoopState,
  input wire logic [1:0] holdoverExitStep
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // read decodes
  wire r7b = rdReq && rdAddr == 16'h007b;
  wire r7c = rdReq && rdAddr == 16'h007c;
  wire r7d = rdReq && rdAddr == 16'h007d;
  wire r82 = rdReq && rdAddr == 16'h0082;
  wire r86 = rdReq && rdAddr == 16'h0086;
  // field checks on read answers and on alarm_r
  a_summary_bit: assert property (r7b |=> rdData_r == {7'h0, $past(alarm_r)})
    else $error("summary byte wrong");
  a_near_lock: assert property (r7c && !$past(reset) |=>
    rdData_r[7] == ($past(refLockCount, 2) >= ($past(refLockLimit, 2) >> 4)))
    else $error("near lock bit wrong");
  a_both_locked: assert property (r7d |=> rdData_r[3] == $past(refLocked && outLoopLocked))
    else $error("both locked bit wrong");
  a_phase_stable: assert property (r7d |=> rdData_r[2] == $past(phaseStable))
    else $error("phase stable bit wrong");
  a_sync_clears: assert property ((syncPulse || syncRequest) ##1 r7d |=> !rdData_r[1])
    else $error("never synced still set");
  a_select_state: assert property (r82 |=> rdData_r ==
    {1'b0, $past(preferredInput), $past(activeInputIndex), $past(referenceLoopState)})
    else $error("select state byte wrong");
  a_exit_step: assert property (r86 |=> rdData_r == {3'h0, $past(holdoverExitStep), 3'h0})
    else $error("exit step byte wrong");
  a_mask_gate: assert property ($past(referenceLoopMask) == 8'h00 &&
    $past(alarmMask) == 8'h00 |-> !alarm_r)
    else $error("alarm without mask");
  // main scenarios
  c_sync_read: cover property ((syncPulse || syncRequest) ##1 r7d);
  c_alarm_read: cover property (r7b ##1 rdData_r[0]);
  c_near_read: cover property (r7c ##1 rdData_r[7]);
endmodule

bind cas_alarm_readback cas_alarm_readback_sva #(.CNT_W(CNT_W)) chk (.clk(clk), .reset(reset),
  .rdReq(rdReq), .rdAddr(rdAddr), .rdData_r(rdData_r), .alarm_r(alarm_r),
  .referenceLoopMask(referenceLoopMask), .alarmMask(alarmMask), .refLockCount(refLockCount),
  .refLockLimit(refLockLimit), .refLocked(refLocked), .outLoopLocked(outLoopLocked),
  .phaseStable(phaseStable), .syncPulse(syncPulse), .syncRequest(syncRequest),
  .preferredInput(preferredInput), .activeInputIndex(activeInputIndex),
  .referenceLoopState(referenceLoopState), .holdoverExitStep(holdoverExitStep));

// *** sim/test_clock_alarm_status_readback.sv ***
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
  $display("[FAIL] %s expected %h seen %h", n, e, g); bad_count++; end end
module test_clock_alarm_status_readback;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, reset, rdReq, latchClearReq, syncRequest, syncPulse, rdValid_r, alarm_r;
  logic neverSynced;
  logic [15:0] rdAddr;
  logic [7:0] rdData_r, latchedModel;
  logic [127:0] s;
  int bad_count, tests_run;
  wire [7:0] ev = {1'b0, s[37], s[0], s[2], s[6:3]};
  // design with status taken from slices of one random word
  cas_alarm_readback dut (.clk(clk), .reset(reset), .rdReq(rdReq), .rdAddr(rdAddr),
    .rdData_r(rdData_r), .rdValid_r(rdValid_r), .latchClearReq(latchClearReq),
    .syncRequest(syncRequest), .referenceLoopMask(s[46:39]), .alarmMask(s[54:47]),
    .refLockCount(s[70:55]), .refLockLimit(s[86:71]), .refAcquiring(s[0]), .refLocked(s[1]),
    .refHoldover(s[2]), .lossOfSignal(s[6:3]), .preferredInput(s[8:7]),
    .activeInputIndex(s[10:9]), .referenceLoopState(s[13:11]), .dacAverage(s[20:14]),
    .dacCurrent(s[27:21]), .holdoverComparator(s[28]), .activeInputLoss(s[29]),
    .referenceFaster(s[30]), .holdoverAdcMoving(s[31]), .tuneOutOfRange(s[32]),
    .holdoverExitStep(s[34:33]), .outLockCount(s[102:87]), .outLockLimit(s[118:103]),
    .outLoopLocked(s[35]), .outLoopDisabled(s[36]), .outLoopAcquiring(s[37]),
    .phaseStable(s[38]), .syncPulse(syncPulse), .alarm_r(alarm_r));
  // expected byte at each address
  function automatic logic [7:0] model(input logic [15:0] a);
    logic [7:0] c, d;
    c = {s[70:55] >= (s[86:71] >> 4), s[0], s[1], s[2], s[6:3]};
    d = {3'h0, (s[35] | s[36]) & neverSynced, s[1] & s[35], s[38], neverSynced,
      s[102:87] >= (s[118:103] >> 4)};
    case (a)
      16'h007b: return {7'h0, |(s[46:39] & c) | |(s[54:47] & d)};
      16'h007c: return c;
      16'h007d: return d;
      16'h007e: return latchedModel;
      16'h0082: return {1'b0, s[8:7], s[10:9], s[13:11]};
      16'h0083: return {1'b0, s[20:14]};
      16'h0084: return {s[28], s[27:21]};
      16'h0085: return {4'h0, s[29], s[30], s[31], s[32]};
      16'h0086: return {3'h0, s[34:33], 3'h0};
      default: return 8'h00;
    endcase
  endfunction
  // one read, entered at a falling edge, leaves rdReq high
  task automatic rd(input logic [15:0] a);
    rdReq = 1'b1;
    rdAddr = a;
    @(negedge clk);
    `CHK("rdValid_r", 1'b1, rdValid_r)
    `CHK($sformatf("reg %h", a), model(a), rdData_r)
  endtask
  task automatic do_reset();
    reset = 1'b1;
    repeat (4) @(negedge clk);
    `CHK("alarm_r reset", 1'b0, alarm_r)
    `CHK("rdData_r reset", 8'h00, rdData_r)
    `CHK("rdValid_r reset", 1'b0, rdValid_r)
    reset = 1'b0;
    neverSynced = 1'b1;
    latchedModel = 8'h00;
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // hang guard
  initial begin
    #50000;
    bad_count++;
    end_of_test();
  end
  // main sequence
  initial begin
    s = '0;
    rdReq = 1'b0;
    rdAddr = 16'h0;
    latchClearReq = 1'b0;
    syncRequest = 1'b0;
    syncPulse = 1'b0;
    bad_count = 0;
    tests_run = 0;
    void'($urandom(32'h7285));
    do_reset();
    for (int i = 0; i < 40; i++) begin
      s = {$urandom, $urandom, $urandom, $urandom};
      if (i % 3 == 0) s[54:39] = 16'h0;
      if (i % 3 == 1) s[54:39] = 16'h1 << (i % 16);
      if (i % 5 == 0) s[102:55] = 48'h0;
      if (i == 25) do_reset();
      latchClearReq = (i % 4 == 3);
      @(negedge clk);
      latchClearReq = 1'b0;
      repeat (3) @(negedge clk);
      latchedModel = (i % 4 == 3) ? ev : latchedModel | ev;
      if (i == 15) syncRequest = 1'b1;
      if (i == 30) syncPulse = 1'b1;
      if (i == 15 || i == 30) begin
        @(negedge clk);
        syncRequest = 1'b0;
        syncPulse = 1'b0;
        neverSynced = 1'b0;
        rd(16'h007d);
      end
      rd(16'h007c);
      rd(16'h007d);
      rd(16'h007e);
      rd(16'h007f);
      rd(16'h0082);
      rd(16'h0083);
      rd(16'h0084);
      rd(16'h0085);
      rd(16'h0086);
      rd(16'h0087);
      rd(16'h0080);
      rd(16'h007b);
      `CHK("alarm_r", model(16'h007b), {7'h0, alarm_r})
      rdReq = 1'b0;
      @(negedge clk);
      `CHK("rdValid_r low", 1'b0, rdValid_r)
      `CHK("rdData_r hold", model(16'h007b), rdData_r)
    end
    end_of_test();
  end
endmodule
